// ---- design/dsg_cmp.sv ----
module dsg_cmp import dsg_pkg::*; #(
  parameter int NUM_BP = DSG_NUM_BP,
  parameter int NUM_WP = DSG_NUM_WP
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  dsg_cmp_if.cmp bus,
  input wire logic i_fetch_vld,
  input wire logic [31:0] i_fetch_addr,
  input wire logic i_data_vld,
  input wire logic [31:0] i_data_val,
  output logic [NUM_BP-1:0] o_bp_hit,
  output logic [NUM_WP-1:0] o_wp_hit
);
  // Index space holds 4 + 2 comparators below the enable word
  if (NUM_BP != 4 || NUM_WP != 2) begin : g_chk
    $error("dsg_cmp: comparator counts must fit the index map");
  end
  localparam int NUM_C = NUM_BP + NUM_WP;
  logic [31:0] val_ff [NUM_C];
  logic [31:0] nxt_val [NUM_C];
  logic [NUM_C-1:0] en_ff;
  logic [NUM_C-1:0] nxt_en;
  logic [NUM_BP-1:0] bp_ff;
  logic [NUM_BP-1:0] nxt_bp;
  logic [NUM_WP-1:0] wp_ff;
  logic [NUM_WP-1:0] nxt_wp;

  always_comb begin
    nxt_en = en_ff;
    if (bus.wr && bus.idx == DSG_IDX_EN) begin
      nxt_en = bus.wdata[NUM_C-1:0];
    end
    for (int i = 0; i < NUM_C; i++) begin
      nxt_val[i] = val_ff[i];
      if (bus.wr && bus.idx == 3'(i)) begin
        nxt_val[i] = bus.wdata;
      end
    end
    // Comparators stay silent whenever the gate has debug shut off
    for (int i = 0; i < NUM_BP; i++) begin
      nxt_bp[i] = bus.dbg_en && en_ff[i] && i_fetch_vld && i_fetch_addr == val_ff[i];
    end
    for (int i = 0; i < NUM_WP; i++) begin
      nxt_wp[i] = bus.dbg_en && en_ff[NUM_BP+i] && i_data_vld
        && i_data_val == val_ff[NUM_BP+i];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < NUM_C; i++) begin
        val_ff[i] <= DSG_CMP_RST;
      end
      en_ff <= '0;
      bp_ff <= '0;
      wp_ff <= '0;
    end else begin
      val_ff <= nxt_val;
      en_ff <= nxt_en;
      bp_ff <= nxt_bp;
      wp_ff <= nxt_wp;
    end
  end

  always_comb begin
    bus.rdata = 32'h0000_0000;
    if (bus.idx == DSG_IDX_EN) begin
      bus.rdata[NUM_C-1:0] = en_ff;
    end else if (bus.idx < 3'(NUM_C)) begin
      bus.rdata = val_ff[bus.idx];
    end
  end

  assign o_bp_hit = bp_ff;
  assign o_wp_hit = wp_ff;

  a_bp_hit_cause: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_bp_hit[0] |-> $past(i_fetch_vld && bus.dbg_en && i_fetch_addr == val_ff[0]))
    else $error("breakpoint hit without matching fetch");
  a_wp_hit_cause: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_wp_hit[1] |-> $past(i_data_vld && en_ff[NUM_BP+1] && i_data_val == val_ff[NUM_BP+1]))
    else $error("watchpoint hit without matching data");
  c_bp_hit: cover property (@(posedge i_clock) disable iff (!i_rst_b) o_bp_hit != '0);
endmodule

// ---- design/dsg_cmp_if.sv ----
interface dsg_cmp_if;
  logic wr;
  logic [2:0] idx;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic dbg_en;
  modport host (output wr, output idx, output wdata, output dbg_en, input rdata);
  modport cmp (input wr, input idx, input wdata, input dbg_en, output rdata);
endinterface

// ---- design/dsg_gate.sv ----
module dsg_gate import dsg_pkg::*; (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_nvm_dbg_dis,
  input wire logic i_nvm_secure,
  input wire logic i_fw_dbg_disable,
  input wire logic i_fw_secure,
  input wire logic i_test_req,
  input wire logic i_flash_prog_req,
  input wire logic i_swclk,
  input wire logic i_swdio,
  output logic o_swdio,
  output logic o_swdio_oe_b,
  input wire logic i_fetch_vld,
  input wire logic [31:0] i_fetch_addr,
  input wire logic i_data_vld,
  input wire logic [31:0] i_data_val,
  output logic [DSG_NUM_BP-1:0] o_bp_hit,
  output logic [DSG_NUM_WP-1:0] o_wp_hit,
  output logic o_debug_en,
  output logic o_secure,
  output logic o_test_en,
  output logic o_flash_prog_en
);
  dsg_cmp_if cmp_bus ();

  // Pin synchronisers; only the second stage and its delayed copy are read
  logic clk_s1_ff, clk_s2_ff, clk_s3_ff, dio_s1_ff, dio_s2_ff;
  logic rise;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      clk_s3_ff <= 1'b0;
      dio_s1_ff <= 1'b0;
      dio_s2_ff <= 1'b0;
    end else begin
      clk_s1_ff <= i_swclk;
      clk_s2_ff <= clk_s1_ff;
      clk_s3_ff <= clk_s2_ff;
      dio_s1_ff <= i_swdio;
      dio_s2_ff <= dio_s1_ff;
    end
  end
  assign rise = clk_s2_ff && !clk_s3_ff;

  // Gate state
  dsg_state_t state_ff, nxt_state;
  logic dbg_off_ff, nxt_dbg_off, secure_ff, nxt_secure;
  logic test_en_ff, nxt_test_en, prog_en_ff, nxt_prog_en, dbg_en_ff, nxt_dbg_en;
  logic locked;

  always_comb begin
    nxt_dbg_off = dbg_off_ff;
    nxt_secure = secure_ff;
    if (state_ff == DSG_ST_BOOT) begin
      // Stored settings are taken before the port leaves boot
      nxt_dbg_off = i_nvm_dbg_dis;
      nxt_secure = i_nvm_secure;
    end
    // No path clears either flag; only a reset reloads them from storage
    if (i_fw_dbg_disable) begin
      nxt_dbg_off = 1'b1;
    end
    if (i_fw_secure) begin
      nxt_secure = 1'b1;
    end
    nxt_dbg_en = !nxt_dbg_off && !nxt_secure;
    // A flash sequence in flight is cut on the same edge that security lands
    nxt_test_en = i_test_req && !nxt_secure && state_ff != DSG_ST_BOOT;
    nxt_prog_en = i_flash_prog_req && !nxt_secure && state_ff != DSG_ST_BOOT;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dbg_off_ff <= DSG_DBG_OFF_RST;
      secure_ff <= DSG_SECURE_RST;
      dbg_en_ff <= 1'b0;
      test_en_ff <= 1'b0;
      prog_en_ff <= 1'b0;
    end else begin
      dbg_off_ff <= nxt_dbg_off;
      secure_ff <= nxt_secure;
      dbg_en_ff <= nxt_dbg_en;
      test_en_ff <= nxt_test_en;
      prog_en_ff <= nxt_prog_en;
    end
  end
  assign locked = nxt_dbg_off || nxt_secure;

  // Serial port engine
  logic [5:0] cnt_ff, nxt_cnt;
  logic [7:0] req_ff, nxt_req;
  logic [32:0] sh_ff, nxt_sh;
  logic rnw_ff, nxt_rnw, out_ff, nxt_out, oe_b_ff, nxt_oe_b, wr_ff, nxt_wr;
  logic [2:0] idx_ff, nxt_idx;
  logic [7:0] req_in;
  logic [31:0] rd_word;

  function automatic logic req_good(input logic [7:0] r);
    req_good = r[0] && !r[6] && r[7] && (^r[4:1] == r[5]);
  endfunction

  assign req_in = {dio_s2_ff, req_ff[7:1]};
  always_comb begin
    rd_word = cmp_bus.rdata;
    if (idx_ff == DSG_IDX_STAT) begin
      rd_word = {30'h0, secure_ff, dbg_en_ff};
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_req = req_ff;
    nxt_sh = sh_ff;
    nxt_rnw = rnw_ff;
    nxt_idx = idx_ff;
    nxt_out = out_ff;
    nxt_oe_b = oe_b_ff;
    nxt_wr = 1'b0;
    if (state_ff == DSG_ST_BOOT) begin
      nxt_state = DSG_ST_IDLE;
    end else if (locked) begin
      // Locked port never answers and drops any transfer under way
      nxt_state = DSG_ST_IDLE;
      nxt_oe_b = 1'b1;
    end else if (rise) begin
      case (state_ff)
        DSG_ST_IDLE: begin
          if (dio_s2_ff) begin
            nxt_state = DSG_ST_REQ;
            nxt_req = req_in;
            nxt_cnt = 6'h01;
          end
        end
        DSG_ST_REQ: begin
          nxt_req = req_in;
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff == DSG_REQ_LAST) begin
            // Malformed headers get no reply, as the probe expects
            nxt_state = req_good(req_in) ? DSG_ST_TRN1 : DSG_ST_IDLE;
            nxt_rnw = req_in[2];
            nxt_idx = {req_in[1], req_in[4:3]};
          end
        end
        DSG_ST_TRN1: begin
          nxt_state = DSG_ST_ACK;
          nxt_oe_b = 1'b0;
          nxt_out = DSG_ACK_OK[0];
          nxt_cnt = 6'h01;
        end
        DSG_ST_ACK: begin
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff != DSG_ACK_LAST) begin
            nxt_out = DSG_ACK_OK[cnt_ff[1:0]];
          end else if (rnw_ff) begin
            nxt_state = DSG_ST_DATA;
            nxt_sh = {^rd_word, rd_word};
            nxt_out = rd_word[0];
            nxt_cnt = 6'h01;
          end else begin
            nxt_state = DSG_ST_TRN2;
            nxt_oe_b = 1'b1;
          end
        end
        DSG_ST_DATA: begin
          nxt_cnt = cnt_ff + 6'h01;
          if (rnw_ff) begin
            nxt_sh = {1'b0, sh_ff[32:1]};
            nxt_out = sh_ff[1];
            if (cnt_ff == DSG_DATA_LAST) begin
              nxt_state = DSG_ST_TRN2;
              nxt_oe_b = 1'b1;
            end
          end else begin
            nxt_sh = {dio_s2_ff, sh_ff[32:1]};
            if (cnt_ff == DSG_DATA_LAST - 6'h01) begin
              nxt_state = DSG_ST_IDLE;
              nxt_wr = (^nxt_sh[31:0] == nxt_sh[32]) && idx_ff != DSG_IDX_STAT;
            end
          end
        end
        DSG_ST_TRN2: begin
          nxt_state = rnw_ff ? DSG_ST_IDLE : DSG_ST_DATA;
          nxt_cnt = 6'h00;
        end
        default: begin
          nxt_state = DSG_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= DSG_ST_BOOT;
      cnt_ff <= 6'h00;
      req_ff <= 8'h00;
      sh_ff <= 33'h0_0000_0000;
      rnw_ff <= 1'b0;
      idx_ff <= 3'h0;
      out_ff <= 1'b0;
      oe_b_ff <= 1'b1;
      wr_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      req_ff <= nxt_req;
      sh_ff <= nxt_sh;
      rnw_ff <= nxt_rnw;
      idx_ff <= nxt_idx;
      out_ff <= nxt_out;
      oe_b_ff <= nxt_oe_b;
      wr_ff <= nxt_wr;
    end
  end

  assign cmp_bus.wr = wr_ff;
  assign cmp_bus.idx = idx_ff;
  assign cmp_bus.wdata = sh_ff[31:0];
  assign cmp_bus.dbg_en = dbg_en_ff;

  dsg_cmp #(.NUM_BP(DSG_NUM_BP), .NUM_WP(DSG_NUM_WP)) u_cmp (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .bus(cmp_bus),
    .i_fetch_vld(i_fetch_vld),
    .i_fetch_addr(i_fetch_addr),
    .i_data_vld(i_data_vld),
    .i_data_val(i_data_val),
    .o_bp_hit(o_bp_hit),
    .o_wp_hit(o_wp_hit)
  );

  assign o_swdio = out_ff;
  assign o_swdio_oe_b = oe_b_ff;
  assign o_debug_en = dbg_en_ff;
  assign o_secure = secure_ff;
  assign o_test_en = test_en_ff;
  assign o_flash_prog_en = prog_en_ff;

  default clocking dsg_cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  a_boot_sample: assert property (state_ff == DSG_ST_BOOT && !i_fw_dbg_disable && !i_fw_secure
    |=> o_debug_en == !($past(i_nvm_dbg_dis) || $past(i_nvm_secure)))
    else $error("stored settings not taken at boot");
  a_boot_silent: assert property (state_ff == DSG_ST_BOOT |-> o_swdio_oe_b && !o_test_en)
    else $error("port active before settings taken");
  a_fw_disable: assert property (i_fw_dbg_disable |=> !o_debug_en [*3])
    else $error("firmware disable did not turn debug off");
  a_dbg_stays_off: assert property (dbg_off_ff |=> dbg_off_ff && !o_debug_en)
    else $error("debug came back on without reset");
  a_locked_silent: assert property (dbg_off_ff |=> o_swdio_oe_b && !cmp_bus.wr)
    else $error("port answered while debug off");
  a_secure_sticky: assert property ($rose(secure_ff) |-> secure_ff [*8])
    else $error("security setting was undone");
  a_secure_block: assert property (secure_ff |=> o_swdio_oe_b && !o_test_en && !o_flash_prog_en)
    else $error("access open under security");
  a_ack_drive: assert property (state_ff == DSG_ST_TRN1 && rise && !locked
    |=> !o_swdio_oe_b && o_swdio == DSG_ACK_OK[0] && state_ff == DSG_ST_ACK)
    else $error("acknowledge not driven after turnaround");
  a_write_end: assert property (cmp_bus.wr |-> state_ff == DSG_ST_IDLE && !rnw_ff)
    else $error("comparator write outside a write transfer");

  c_write: cover property (cmp_bus.wr);
  c_read_done: cover property (state_ff == DSG_ST_DATA && rnw_ff ##1 state_ff == DSG_ST_TRN2);
  c_secure: cover property ($rose(secure_ff));
endmodule

// ---- design/dsg_pkg.sv ----
// Summary of operation
// - Debug is on after reset unless the stored settings disable it or set security, and a firmware control can switch it off.
// - Once firmware switches debug off, nothing turns it back on short of a reset, which reloads the stored setting.
// - A device-security setting shuts the external interfaces until a reset reloads the stored setting, with no command to undo it.
// - Under security all programming, debug and test access is blocked, also mid-sequence.
// - Four address breakpoint comparators and two data watchpoint comparators serve the probe.
// - Programming and debug run over the two-wire serial port only, which the probe must use.
package dsg_pkg;
  localparam int DSG_NUM_BP = 4;
  localparam int DSG_NUM_WP = 2;
  localparam int DSG_DATA_BITS = 32;
  localparam int DSG_REQ_BITS = 8;
  localparam int DSG_ACK_BITS = 3;
  localparam logic [2:0] DSG_ACK_OK = 3'h1;
  localparam logic [5:0] DSG_REQ_LAST = 6'h07;
  localparam logic [5:0] DSG_ACK_LAST = 6'h03;
  localparam logic [5:0] DSG_DATA_LAST = 6'h21;
  localparam logic [2:0] DSG_IDX_BP0 = 3'h0;
  localparam logic [2:0] DSG_IDX_WP0 = 3'h4;
  localparam logic [2:0] DSG_IDX_EN = 3'h6;
  localparam logic [2:0] DSG_IDX_STAT = 3'h7;
  localparam logic [31:0] DSG_CMP_RST = 32'h0000_0000;
  localparam logic DSG_DBG_OFF_RST = 1'b0;
  localparam logic DSG_SECURE_RST = 1'b0;
  typedef enum logic [6:0] {
    DSG_ST_BOOT = 7'b0000001,
    DSG_ST_IDLE = 7'b0000010,
    DSG_ST_REQ = 7'b0000100,
    DSG_ST_TRN1 = 7'b0001000,
    DSG_ST_ACK = 7'b0010000,
    DSG_ST_DATA = 7'b0100000,
    DSG_ST_TRN2 = 7'b1000000
  } dsg_state_t;
endpackage

// ---- verif/dsg_gate_tb.sv ----
module dsg_gate_tb import dsg_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_nvm_dbg_dis = 1'b0;
  logic i_nvm_secure = 1'b0;
  logic i_fw_dbg_disable = 1'b0;
  logic i_fw_secure = 1'b0;
  logic i_test_req = 1'b0;
  logic i_flash_prog_req = 1'b0;
  logic i_fetch_vld = 1'b0;
  logic [31:0] i_fetch_addr = 32'h0000_0000;
  logic i_data_vld = 1'b0;
  logic [31:0] i_data_val = 32'h0000_0000;
  logic swclk, swdio_line, o_swdio, o_swdio_oe_b, p_drive, p_val;
  logic [DSG_NUM_BP-1:0] o_bp_hit;
  logic [DSG_NUM_WP-1:0] o_wp_hit;
  logic o_debug_en, o_secure, o_test_en, o_flash_prog_en;
  logic off_seen = 1'b0;
  logic [31:0] cmp_val [6];
  int fails = 0;
  int cmp_count = 0;
  int leaks = 0;
  int seed = 64;

  always #2.5 i_clock = ~i_clock;

  // Pull-up on the data line when nobody drives it
  assign swdio_line = !o_swdio_oe_b ? o_swdio : (p_drive ? p_val : 1'b1);

  dsg_gate uut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_nvm_dbg_dis(i_nvm_dbg_dis),
    .i_nvm_secure(i_nvm_secure), .i_fw_dbg_disable(i_fw_dbg_disable),
    .i_fw_secure(i_fw_secure), .i_test_req(i_test_req), .i_flash_prog_req(i_flash_prog_req),
    .i_swclk(swclk), .i_swdio(swdio_line), .o_swdio(o_swdio), .o_swdio_oe_b(o_swdio_oe_b),
    .i_fetch_vld(i_fetch_vld), .i_fetch_addr(i_fetch_addr), .i_data_vld(i_data_vld),
    .i_data_val(i_data_val), .o_bp_hit(o_bp_hit), .o_wp_hit(o_wp_hit),
    .o_debug_en(o_debug_en), .o_secure(o_secure), .o_test_en(o_test_en),
    .o_flash_prog_en(o_flash_prog_en));

  dsg_probe probe (.i_clock(i_clock), .i_line(swdio_line), .o_swclk(swclk),
    .o_drive(p_drive), .o_val(p_val));

  // One cycle of grace after the port is shut; contention counts as well
  always @(negedge i_clock) begin
    if ((off_seen || p_drive) && !o_swdio_oe_b) leaks++;
    off_seen <= !o_debug_en && i_rst_b;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [31:0] stat_word(input logic sec, input logic en);
    return {30'h0, sec, en};
  endfunction

  function automatic logic [31:0] hit_mask(input int k, input logic on);
    return (on && k < 6) ? 32'h0000_0001 << k : 32'h0000_0000;
  endfunction

  task automatic do_reset(input logic dis, input logic sec);
    @(negedge i_clock);
    i_rst_b = 1'b0;
    i_nvm_dbg_dis = dis;
    i_nvm_secure = sec;
    repeat (8) @(negedge i_clock);
    i_rst_b = 1'b1;
    repeat (6) @(negedge i_clock);
    check("debug_en", o_debug_en, !dis && !sec);
    check("secure", o_secure, sec);
  endtask

  task automatic pulse(input logic sel);
    @(negedge i_clock);
    if (sel) i_fw_secure = 1'b1;
    else i_fw_dbg_disable = 1'b1;
    @(negedge i_clock);
    i_fw_secure = 1'b0;
    i_fw_dbg_disable = 1'b0;
  endtask

  task automatic hit_test(input logic on);
    for (int k = 0; k < 7; k++) begin
      @(negedge i_clock);
      i_fetch_vld = (k < 4) || (k == 6);
      i_data_vld = (k >= 4);
      i_fetch_addr = (k < 6) ? cmp_val[k] : $random(seed);
      i_data_val = (k < 6) ? cmp_val[k] : ~i_fetch_addr;
      @(negedge i_clock);
      i_fetch_vld = 1'b0;
      i_data_vld = 1'b0;
      check("hits", {o_wp_hit, o_bp_hit}, hit_mask(k, on));
    end
  endtask

  initial begin
    repeat (90000) @(posedge i_clock);
    fails++;
    conclude();
  end

  initial begin
    logic [2:0] ack;
    logic [31:0] rd;
    do_reset(1'b0, 1'b0);
    for (int k = 0; k < 6; k++) begin
      cmp_val[k] = $random(seed);
      probe.xfer(1'b0, 3'(k), cmp_val[k], ack, rd);
      check("write ack", ack, DSG_ACK_OK);
    end
    probe.xfer(1'b0, DSG_IDX_EN, 32'h0000_003F, ack, rd);
    probe.xfer(1'b0, DSG_IDX_STAT, 32'hFFFF_FFFF, ack, rd);
    for (int k = 0; k < 6; k++) begin
      probe.xfer(1'b1, 3'(k), 32'h0000_0000, ack, rd);
      check("readback", rd, cmp_val[k]);
    end
    probe.xfer(1'b1, DSG_IDX_STAT, 32'h0000_0000, ack, rd);
    check("status", rd, stat_word(1'b0, 1'b1));
    hit_test(1'b1);
    $display("Test comparators done");
    @(negedge i_clock);
    i_test_req = 1'b1;
    i_flash_prog_req = 1'b1;
    repeat (2) @(negedge i_clock);
    check("test_en", o_test_en, 1'b1);
    check("prog_en", o_flash_prog_en, 1'b1);
    pulse(1'b0);
    check("debug_en", o_debug_en, 1'b0);
    probe.xfer(1'b1, DSG_IDX_STAT, 32'h0000_0000, ack, rd);
    check("refused ack", ack, 3'h7);
    probe.xfer(1'b0, DSG_IDX_EN, 32'h0000_003F, ack, rd);
    hit_test(1'b0);
    check("debug_en", o_debug_en, 1'b0);
    do_reset(1'b1, 1'b0);
    do_reset(1'b0, 1'b0);
    $display("Test debug disable done");
    fork
      probe.xfer(1'b1, DSG_IDX_STAT, 32'h0000_0000, ack, rd);
      begin
        repeat (200) @(negedge i_clock);
        pulse(1'b1);
      end
    join
    check("secure", o_secure, 1'b1);
    check("debug_en", o_debug_en, 1'b0);
    for (int k = 0; k < 20; k++) begin
      @(negedge i_clock);
      i_test_req = $random(seed);
      i_flash_prog_req = $random(seed);
      check("prog_en", {o_test_en, o_flash_prog_en}, 2'h0);
    end
    probe.xfer(1'b1, DSG_IDX_STAT, 32'h0000_0000, ack, rd);
    check("refused ack", ack, 3'h7);
    do_reset(1'b0, 1'b1);
    check("port leaks", leaks, 0);
    $display("Test security done");
    conclude();
  end
endmodule

// ---- verif/dsg_probe.sv ----
module dsg_probe import dsg_pkg::*; (
  input wire logic i_clock,
  input wire logic i_line,
  output logic o_swclk,
  output logic o_drive,
  output logic o_val
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_swclk = 1'b0;
    o_drive = 1'b0;
    o_val = 1'b0;
  end

  // Four clocks low and five high, so the two-flop synchroniser always sees each rise
  task automatic rise(input logic drv, input logic v, output logic smp);
    @(posedge i_clock);
    o_swclk <= 1'b0;
    o_drive <= drv;
    o_val <= v;
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    smp = i_line;
    @(posedge i_clock);
    o_swclk <= 1'b1;
    repeat (4) @(posedge i_clock);
  endtask

  task automatic xfer(input logic rnw, input logic [2:0] idx, input logic [31:0] wd,
                      output logic [2:0] ack, output logic [31:0] rd);
    logic [7:0] req;
    logic [32:0] bits;
    logic s;
    req = {1'b1, 1'b0, ^{idx, rnw}, idx[1], idx[0], rnw, idx[2], 1'b1};
    bits = {^wd, wd};
    rd = 32'h0000_0000;
    for (int i = 0; i < 8; i++) rise(1'b1, req[i], s);
    // Each sample shows what the port put out at the previous rise, so one turnaround rise
    rise(1'b0, 1'b0, s);
    for (int i = 0; i < 3; i++) rise(1'b0, 1'b0, ack[i]);
    if (ack == DSG_ACK_OK) begin
      if (!rnw) begin
        rise(1'b0, 1'b0, s);
      end
      for (int i = 0; i < 33; i++) rise(!rnw, bits[i], bits[i]);
      rd = bits[31:0];
      // Holding the line low keeps the idle port from seeing a start bit
      rise(1'b1, 1'b0, s);
    end
    @(posedge i_clock);
    o_swclk <= 1'b0;
    o_drive <= 1'b0;
  endtask
endmodule
